// ===== phc_port_handshake.sv
// Handshake engines for three byte ports with strobes on port 3
`timescale 1ns/10ps
`default_nettype none
`include "phc_consts.svh"
// ----------------------------------------------------------------------
// Operation
// - Each port runs input or output handshake
// - Input mode: take byte when valid strobe falls
// - Output mode: next byte follows accept going low
// - Incoming line falling edge raises port interrupt
// - Strobe held high while accept line low
// - Writing a byte drives strobe low
// - Accept low forces strobe high until next byte
// - First byte may be written without checking
// - Later port 2 bytes follow its interrupt
// - Port 0 input: bit 6 set, 7 clear
// - Port 1 input: bit 3 set, 4 clear
// - Port 0 output: bits 6 and 7 set
// - Port 1 output: bits 3 and 4 set
// - Cleared port 2 direction drives all bits
// - Strobe idles at port 3 data level
// - Port 2 enable: mode bit 5, data bit 6
// - Port 1 enable: data bit 4, mode 3-4
// ----------------------------------------------------------------------

module phc_port_handshake (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] port01_mode_reg_i,
    input wire logic [7:0] port2_direction_reg_i,
    input wire logic [7:0] port3_mode_reg_i,
    input wire logic [7:0] port3_data_reg_i,
    input wire logic [2:0] wr_stb_i,
    input wire logic [7:0] wr_data_i,
    output logic [2:0] wr_ready_o,
    input wire logic [2:0] rd_ack_i,
    output logic [2:0] rd_valid_o,
    output logic [7:0] rd_data0_o,
    output logic [7:0] rd_data1_o,
    output logic [7:0] rd_data2_o,
    input wire logic [7:0] port0_pin_i,
    input wire logic [7:0] port1_pin_i,
    input wire logic [7:0] port2_pin_i,
    output logic [7:0] port0_pin_o,
    output logic [7:0] port0_pin_oe_o,
    output logic [7:0] port1_pin_o,
    output logic [7:0] port1_pin_oe_o,
    output logic [7:0] port2_pin_o,
    output logic [7:0] port2_pin_oe_o,
    input wire logic port3_line2_i,
    input wire logic port3_line3_i,
    input wire logic port3_line1_i,
    output logic port3_line5_o,
    output logic port3_line5_oe_o,
    output logic port3_line4_o,
    output logic port3_line4_oe_o,
    output logic port3_line6_o,
    output logic port3_line6_oe_o,
    output logic handshake_int_port0_o,
    output logic handshake_int_port1_o,
    output logic handshake_int_port2_o
);
    import phc_pkg::*;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    function automatic phc_mode_type mode_of(input logic en,
                                             input logic is_in,
                                             input logic is_out);
        phc_mode_type m;
        m = phc_hs_off;
        if (en && is_out) begin
            m = phc_hs_out;
        end else if (en && is_in) begin
            m = phc_hs_in;
        end
        return m;
    endfunction

    phc_mode_type mode_next [3];
    phc_mode_type mode_reg [3];
    logic [2:0] a_raw;
    logic [2:0] a_meta_reg;
    logic [2:0] a_sync_reg;
    logic [2:0] a_prev_reg;
    logic [2:0] a_fall;
    logic [2:0][7:0] pin_raw;
    logic [2:0][7:0] pin_meta_reg;
    logic [2:0][7:0] pin_sync_reg;
    logic [2:0][7:0] out_data_reg;
    logic [2:0][7:0] load_data;
    logic [2:0][7:0] oe_reg;
    logic [2:0][7:0] rx_data_reg;
    logic [2:0] pend_reg;
    logic [2:0] dav_reg;
    logic [2:0] rdy_reg;
    logic [2:0] rx_valid_reg;
    logic [2:0] int_reg;
    logic [2:0] load;
    logic [2:0] idle_b;
    logic [2:0] line_b;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;

    // Incoming line A of each port: port 0 on line 2, 1 on 3, 2 on 1
    assign a_raw = {port3_line1_i, port3_line3_i, port3_line2_i};
    assign pin_raw = {port2_pin_i, port1_pin_i, port0_pin_i};
    assign idle_b = {port3_data_reg_i[`PHC_P3D_P2_BIT],
                     port3_data_reg_i[`PHC_P3D_P1_BIT],
                     port3_data_reg_i[`PHC_P3D_P0_BIT]};

    // Each port picks off, input or output from its mode bits
    always_comb begin
        mode_next[0] = mode_of(
            port3_data_reg_i[`PHC_P3D_P0_BIT] &&
            port3_mode_reg_i[`PHC_P3M_P0_EN_BIT],
            port01_mode_reg_i[`PHC_PORT01_MODE_REG_P0_LO_BIT] &&
            !port01_mode_reg_i[`PHC_PORT01_MODE_REG_P0_HI_BIT],
            port01_mode_reg_i[`PHC_PORT01_MODE_REG_P0_LO_BIT] &&
            port01_mode_reg_i[`PHC_PORT01_MODE_REG_P0_HI_BIT]);
        mode_next[1] = mode_of(
            port3_data_reg_i[`PHC_P3D_P1_BIT] &&
            port3_mode_reg_i[`PHC_P3M_P1_EN_LO_BIT] &&
            port3_mode_reg_i[`PHC_P3M_P1_EN_HI_BIT],
            port01_mode_reg_i[`PHC_PORT01_MODE_REG_P1_LO_BIT] &&
            !port01_mode_reg_i[`PHC_PORT01_MODE_REG_P1_HI_BIT],
            port01_mode_reg_i[`PHC_PORT01_MODE_REG_P1_LO_BIT] &&
            port01_mode_reg_i[`PHC_PORT01_MODE_REG_P1_HI_BIT]);
        mode_next[2] = mode_of(
            port3_data_reg_i[`PHC_P3D_P2_BIT] &&
            port3_mode_reg_i[`PHC_P3M_P2_EN_BIT],
            port2_direction_reg_i[`PHC_P2M_HS_BIT],
            !port2_direction_reg_i[`PHC_P2M_HS_BIT]);
    end

    // Registered modes; every engine below except the pin enables and the interrupt requests keys off these
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 3; i++) begin
                mode_reg[i] <= phc_hs_off;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                mode_reg[i] <= mode_next[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Two stages for pins, a third only for edge detection
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_meta_reg <= 3'h7;
            a_sync_reg <= 3'h7;
            a_prev_reg <= 3'h7;
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            a_meta_reg <= a_raw;
            a_sync_reg <= a_meta_reg;
            a_prev_reg <= a_sync_reg;
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign a_fall = a_prev_reg & ~a_sync_reg;

    // Falling incoming line gives a one-cycle request in any mode
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_reg <= 3'h0;
        end else begin
            int_reg <= a_fall;
        end
    end

    // ------------------------------------------------------------------
    // Output path
    // ------------------------------------------------------------------
    // Port 2 bytes queue here so software can run ahead of the link
    phc_fifo #(
        .WIDTH(`PHC_DATA_W),
        .DEPTH(`PHC_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(wr_stb_i[2]),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wr_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(load[2]),
        .out_data_o(fifo_data)
    );

    // A byte reaches the port register; port 2 waits for the last ack
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            load[i] = wr_stb_i[i] && (mode_reg[i] == phc_hs_out);
            load_data[i] = wr_data_i;
        end
        load[2] = fifo_valid && !pend_reg[2] && dav_reg[2] &&
                  (mode_reg[2] == phc_hs_out);
        load_data[2] = fifo_data;
    end

    assign wr_ready_o = {fifo_in_ready, 2'h3};

    // Port data and pending flag; pending means strobe not yet dropped
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_data_reg <= '0;
            pend_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (mode_reg[i] != phc_hs_out) begin
                    pend_reg[i] <= 1'b0;
                end else if (load[i]) begin
                    out_data_reg[i] <= load_data[i];
                    pend_reg[i] <= 1'b1;
                end else if (pend_reg[i] && a_sync_reg[i]) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Outgoing strobe, low means data available
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dav_reg <= 3'h7;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (mode_reg[i] != phc_hs_out) begin
                    dav_reg[i] <= 1'b1;
                end else if (!a_sync_reg[i]) begin
                    dav_reg[i] <= 1'b1;
                end else if (pend_reg[i]) begin
                    dav_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------------
    // Capture wins over a read acknowledge in the same cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdy_reg <= 3'h7;
            rx_valid_reg <= 3'h0;
            rx_data_reg <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (mode_reg[i] != phc_hs_in) begin
                    rdy_reg[i] <= 1'b1;
                    rx_valid_reg[i] <= 1'b0;
                end else if (a_fall[i] && rdy_reg[i]) begin
                    rdy_reg[i] <= 1'b0;
                    rx_valid_reg[i] <= 1'b1;
                    rx_data_reg[i] <= pin_sync_reg[i];
                end else begin
                    if (rd_ack_i[i]) begin
                        rx_valid_reg[i] <= 1'b0;
                    end
                    // Reopen only once read and the strobe is back high
                    if (!rdy_reg[i] && !rx_valid_reg[i] && a_sync_reg[i]) begin
                        rdy_reg[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Port 0 hands over only its high nibble; enables use the decoded
    // mode so that they switch on the same edge as the mode register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_reg <= '0;
        end else begin
            oe_reg[0] <= (mode_next[0] == phc_hs_out) ?
                         `PHC_P0_NIBBLE_OE : `PHC_BYTE_ZERO;
            oe_reg[1] <= (mode_next[1] == phc_hs_out) ?
                         `PHC_BYTE_OE : `PHC_BYTE_ZERO;
            oe_reg[2] <= (mode_next[2] == phc_hs_out) ?
                         ~port2_direction_reg_i : `PHC_BYTE_ZERO;
        end
    end

    // Line B: strobe in output mode, ready in input mode, else data bit
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            case (mode_reg[i])
                phc_hs_out: line_b[i] = dav_reg[i];
                phc_hs_in: line_b[i] = rdy_reg[i];
                default: line_b[i] = idle_b[i];
            endcase
        end
    end

    // Port 0 on line 5, port 1 on line 4, port 2 on line 6
    assign port3_line5_o = line_b[0];
    assign port3_line4_o = line_b[1];
    assign port3_line6_o = line_b[2];
    assign port3_line5_oe_o = 1'b1;
    assign port3_line4_oe_o = 1'b1;
    assign port3_line6_oe_o = 1'b1;
    assign port0_pin_o = out_data_reg[0];
    assign port1_pin_o = out_data_reg[1];
    assign port2_pin_o = out_data_reg[2];
    assign port0_pin_oe_o = oe_reg[0];
    assign port1_pin_oe_o = oe_reg[1];
    assign port2_pin_oe_o = oe_reg[2];
    assign rd_valid_o = rx_valid_reg;
    assign rd_data0_o = rx_data_reg[0];
    assign rd_data1_o = rx_data_reg[1];
    assign rd_data2_o = rx_data_reg[2];
    assign handshake_int_port0_o = int_reg[0];
    assign handshake_int_port1_o = int_reg[1];
    assign handshake_int_port2_o = int_reg[2];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    logic p0_en;
    logic p1_en;
    logic p2_en;
    assign p0_en = port3_data_reg_i[5] && port3_mode_reg_i[2];
    assign p1_en = port3_data_reg_i[4] && port3_mode_reg_i[3] &&
                   port3_mode_reg_i[4];
    assign p2_en = port3_data_reg_i[6] && port3_mode_reg_i[5];

    for (genvar g = 0; g < 3; g++) begin : g_chk
        a_int_on_fall: assert property ($fell(a_sync_reg[g]) |=> int_reg[g])
            else $error("no request after falling line");
        a_no_false_int: assert property (!$fell(a_sync_reg[g]) |=> !int_reg[g])
            else $error("request without falling line");
        a_strobe_waits: assert property ((mode_reg[g] == phc_hs_out) &&
            !a_sync_reg[g] |=> line_b[g])
            else $error("strobe low while accept low");
        a_write_drops: assert property ((load[g] && mode_reg[g] == phc_hs_out)
            ##1 (a_sync_reg[g] && mode_reg[g] == phc_hs_out) |=> !line_b[g])
            else $error("strobe did not fall after write");
        a_strobe_stays: assert property ((mode_reg[g] == phc_hs_out) &&
            dav_reg[g] && !pend_reg[g] && !load[g] |=> dav_reg[g])
            else $error("strobe fell without a new byte");
        a_input_take: assert property ((mode_reg[g] == phc_hs_in) &&
            rdy_reg[g] && a_fall[g] |=> rd_valid_o[g] && !line_b[g] &&
            rx_data_reg[g] == $past(pin_sync_reg[g]))
            else $error("input byte not captured");
    end

    a_p0_out_sel: assert property (p0_en && port01_mode_reg_i[7:6] == 2'h3
        |=> port0_pin_oe_o == 8'hF0 && port3_line5_o == dav_reg[0])
        else $error("port 0 output handshake not selected");
    a_p0_in_sel: assert property (p0_en && port01_mode_reg_i[7:6] == 2'h1
        |=> port0_pin_oe_o == 8'h00 && port3_line5_o == rdy_reg[0])
        else $error("port 0 input handshake not selected");
    a_p1_out_sel: assert property (p1_en && port01_mode_reg_i[4:3] == 2'h3
        |=> port1_pin_oe_o == 8'hFF && port3_line4_o == dav_reg[1])
        else $error("port 1 output handshake not selected");
    a_p1_in_sel: assert property (p1_en && port01_mode_reg_i[4:3] == 2'h1
        |=> port1_pin_oe_o == 8'h00 && port3_line4_o == rdy_reg[1])
        else $error("port 1 input handshake not selected");
    a_p2_drive_all: assert property (p2_en && !port2_direction_reg_i[7]
        |=> port2_pin_oe_o == ~$past(port2_direction_reg_i))
        else $error("port 2 drive mask wrong");
    a_p2_idle_level: assert property (!p2_en
        |=> port3_line6_o == port3_data_reg_i[6])
        else $error("port 2 strobe not at idle level");

    c_out_byte: cover property (load[2] ##[1:20] !port3_line6_o);
    c_in_byte: cover property ($rose(rd_valid_o[1]));
    c_fifo_full: cover property (!wr_ready_o[2]);
    c_accept_int: cover property (handshake_int_port2_o);

endmodule
`default_nettype wire

// ===== phc_consts.svh
// Bit positions, masks and sizes for the port handshake block
`ifndef PHC_CONSTS_SVH
`define PHC_CONSTS_SVH

// ----------------------------------------------------------------------
// Shared port 0/1 mode register fields
// ----------------------------------------------------------------------
`define PHC_PORT01_MODE_REG_P0_LO_BIT 6
`define PHC_PORT01_MODE_REG_P0_HI_BIT 7
`define PHC_PORT01_MODE_REG_P1_LO_BIT 3
`define PHC_PORT01_MODE_REG_P1_HI_BIT 4

// ----------------------------------------------------------------------
// Port 2 direction register: this bit decides the handshake direction
// ----------------------------------------------------------------------
`define PHC_P2M_HS_BIT 7

// ----------------------------------------------------------------------
// Port 3 mode register enables
// ----------------------------------------------------------------------
`define PHC_P3M_P0_EN_BIT 2
`define PHC_P3M_P1_EN_LO_BIT 3
`define PHC_P3M_P1_EN_HI_BIT 4
`define PHC_P3M_P2_EN_BIT 5

// ----------------------------------------------------------------------
// Port 3 data bits: handshake enables and idle strobe levels
// ----------------------------------------------------------------------
`define PHC_P3D_P0_BIT 5
`define PHC_P3D_P1_BIT 4
`define PHC_P3D_P2_BIT 6

// ----------------------------------------------------------------------
// Drive masks, data width and buffer depth
// ----------------------------------------------------------------------
`define PHC_P0_NIBBLE_OE 8'hF0
`define PHC_BYTE_OE 8'hFF
`define PHC_BYTE_ZERO 8'h00
`define PHC_DATA_W 8
`define PHC_FIFO_DEPTH 32

`endif

// ===== phc_pkg.sv
// Types shared by the port handshake block
package phc_pkg;

    // ------------------------------------------------------------------
    // Handshake mode of one port
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        phc_hs_off = 2'b00,
        phc_hs_in = 2'b01,
        phc_hs_out = 2'b10
    } phc_mode_type;

endpackage

// ===== phc_fifo.sv
// Small first-in first-out buffer with a registered read port
`timescale 1ns/10ps
`default_nettype none

module phc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic push;
    logic refill;

    // Refill the read register whenever it is empty or being drained
    assign in_ready_o = (count_reg != FULL);
    assign push = in_valid_i && in_ready_o;
    assign refill = (count_reg != '0) && (!out_valid_reg || out_ready_i);
    assign out_valid_o = out_valid_reg;
    assign out_data_o = out_data_reg;

    // Storage array, no reset so it maps onto plain memory
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers and fill count; depth is a power of two so they wrap
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (refill) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !refill) begin
                count_reg <= count_reg + 1'b1;
            end else if (!push && refill) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Read register, the word presented to the consumer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (refill) begin
            out_valid_reg <= 1'b1;
            out_data_reg <= mem[rd_ptr_reg];
        end else if (out_ready_i) begin
            out_valid_reg <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== phc_periph.sv
// Peripheral model that latches handshaked output bytes
`timescale 1ns/10ps
`default_nettype none

module phc_periph (
    input wire logic clk_i,
    input wire logic strobe_i,
    input wire logic [7:0] data_i,
    input wire logic slow_i,
    output logic accept_o,
    output logic [7:0] got_o,
    output logic got_stb_o
);
    int wait_q = 0;

    // Idle with accept high so the first byte can go at once
    initial begin
        accept_o = 1'b1;
        got_o = 8'h00;
        got_stb_o = 1'b0;
    end

    // Latch on a low strobe, then drop accept; slow mode stalls longer
    always @(posedge clk_i) begin
        got_stb_o <= 1'b0;
        if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end else if (!strobe_i && accept_o) begin
            got_o <= data_i;
            got_stb_o <= 1'b1;
            accept_o <= 1'b0;
            wait_q <= slow_i ? 6 : 1;
        end else if (strobe_i && !accept_o) begin
            accept_o <= 1'b1;
            wait_q <= slow_i ? 6 : 1;
        end
    end
endmodule
`default_nettype wire

// ===== port_handshake_control_bench.sv
// Self-checking bench for the port handshake block
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
`define WT(c) begin n = 0; while (!(c) && n < 1000) begin \
    @(negedge clk); n++; end if (!(c)) miscompares++; end

module port_handshake_control_bench;
    logic clk, rst, l2, acc_hold, sl2;
    logic [7:0] m01, m2d, m3m, m3d, wd, pin0, d, exp2;
    logic [2:0] wstb, rack;
    logic [7:0] rd0, rd1, rd2, p0o, p1o, p2o, p0oe, p1oe, p2oe, gd1, gd2;
    logic [2:0] wrdy, rv;
    logic l4, l5, l6, i0, i1, i2, a1, a2, g1, g2;
    int miscompares = 0, total_checks = 0, n, cyc = 0, full = 0;
    int seed = 32'hfe921aa7;
    logic [7:0] q[$];

    phc_port_handshake i_phc_port_handshake (.core_clk_i(clk),
        .rst_i(rst), .port01_mode_reg_i(m01),
        .port2_direction_reg_i(m2d), .port3_mode_reg_i(m3m),
        .port3_data_reg_i(m3d), .wr_stb_i(wstb), .wr_data_i(wd),
        .wr_ready_o(wrdy), .rd_ack_i(rack), .rd_valid_o(rv),
        .rd_data0_o(rd0), .rd_data1_o(rd1), .rd_data2_o(rd2),
        .port0_pin_i(pin0), .port1_pin_i(pin0), .port2_pin_i(8'h00),
        .port0_pin_o(p0o), .port0_pin_oe_o(p0oe), .port1_pin_o(p1o),
        .port1_pin_oe_o(p1oe), .port2_pin_o(p2o), .port2_pin_oe_o(p2oe),
        .port3_line2_i(l2), .port3_line3_i(a1 & ~acc_hold),
        .port3_line1_i(a2), .port3_line5_o(l5), .port3_line5_oe_o(),
        .port3_line4_o(l4), .port3_line4_oe_o(), .port3_line6_o(l6),
        .port3_line6_oe_o(), .handshake_int_port0_o(i0),
        .handshake_int_port1_o(i1), .handshake_int_port2_o(i2));
    phc_periph i_phc_periph (.clk_i(clk), .strobe_i(l4), .data_i(p1o),
        .slow_i(1'b0), .accept_o(a1), .got_o(gd1), .got_stb_o(g1));
    phc_periph i_phc_periph_2 (.clk_i(clk), .strobe_i(l6), .data_i(p2o),
        .slow_i(sl2), .accept_o(a2), .got_o(gd2), .got_stb_o(g2));

    // ------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // A hang ends the run as a failure rather than stalling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict;
        end
    end

    task give_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One write strobe; a gap cycle keeps strobe edges apart
    task wr(input int p, input logic [7:0] v);
        @(negedge clk);
        while (p == 2 && !wrdy[2]) @(negedge clk);
        wstb[p] = 1'b1;
        wd = v;
        @(negedge clk);
        wstb[p] = 1'b0;
    endtask

    // Port 2 bytes must arrive in write order
    always @(negedge clk) begin
        if (g2 === 1'b1) begin
            exp2 = q.pop_front();
            `CHK(gd2, exp2)
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {l2, acc_hold, sl2, wstb, rack, wd, pin0} = '0;
        l2 = 1'b1;
        m01 = 8'h58;
        m2d = 8'h00;
        m3m = 8'h3C;
        m3d = 8'h70;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK(l4, 1'b1)
        repeat (3) @(negedge clk);
        `CHK(p2oe, 8'hFF)
        `CHK(p1oe, 8'hFF)
        `CHK(p0oe[7:4], 4'h0)
        // Port 1 output bytes, serviced on each interrupt
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            wr(1, d);
            `WT(g1)
            `CHK(gd1, d)
            `WT(i1)
            `CHK(l4, 1'b1)
            `WT(a1)
        end
        // Accept held low: the strobe must wait for it
        acc_hold = 1'b1;
        repeat (4) @(negedge clk);
        d = $random(seed);
        wr(1, d);
        repeat (8) begin
            @(negedge clk);
            `CHK(l4, 1'b1)
        end
        acc_hold = 1'b0;
        `WT(g1)
        `CHK(gd1, d)
        // Port 2 through the buffer with a stalling peer, until full
        sl2 = 1'b1;
        for (int i = 0; i < 40; i++) begin
            if (!wrdy[2]) full++;
            d = $random(seed);
            q.push_back(d);
            wr(2, d);
        end
        `CHK(full != 0, 1'b1)
        sl2 = 1'b0;
        `WT(q.size() == 0)
        repeat (4) @(negedge clk);
        `CHK(wrdy[2], 1'b1)
        // Port 0 input bytes on the high nibble
        for (int i = 0; i < 2; i++) begin
            d = $random(seed);
            pin0 = d;
            l2 = 1'b0;
            `WT(rv[0])
            `CHK(rd0[7:4], d[7:4])
            `CHK(i0, 1'b1)
            `CHK(l5, 1'b0)
            rack[0] = 1'b1;
            l2 = 1'b1;
            pin0 = ~d;
            @(negedge clk);
            rack[0] = 1'b0;
            `WT(l5)
            `CHK(rv[0], 1'b0)
        end
        // Swap roles: port 0 output, ports 1 and 2 input, then port 2 off
        m01 = 8'hC8;
        m2d = 8'h80;
        repeat (3) @(negedge clk);
        `CHK(p0oe, 8'hF0)
        `CHK({p1oe, p2oe}, 16'h0000)
        d = $random(seed);
        pin0 = d;
        acc_hold = 1'b1;
        `WT(rv[1])
        `CHK(rd1, d)
        `CHK(l4, 1'b0)
        wr(0, d);
        `WT(!l5)
        `CHK(p0o, d)
        l2 = 1'b0;
        `WT(i0)
        `CHK(l5, 1'b1)
        m3m = 8'h1C;
        repeat (2) @(negedge clk);
        `CHK(l6, m3d[6])
        give_verdict;
    end
endmodule
`default_nettype wire
